// [hdl/video_port_pkg.sv]
// Shared constants, field layout and types of the parallel video port block.
package video_port_pkg;

    // Widths and counts.
    localparam int COLOUR_WIDTH = 24;
    localparam int FILTER_MIN_CLOCKS = 3;
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;

    // Register byte addresses.
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] STRAP_ADDR = 12'h008;

    // Control register fields and reset values.
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_OSS_BIT = 3;
    localparam int CTRL_SDA_BIT = 4;
    localparam logic EDGE_RESET = 1'b1;
    localparam logic [1:0] MODE_RESET = 2'b00;
    localparam logic OSS_RESET = 1'b0;
    localparam logic SDA_PULL_RESET = 1'b0;

    // Status register fields.
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_POWER_BIT = 1;
    localparam int STAT_SCL_BIT = 2;
    localparam int STAT_SDA_BIT = 3;
    localparam int STAT_STRAP_BIT = 4;
    localparam int STAT_RESERVED_BIT = 5;

    // Position of the control signals above the colour bits in a pixel word.
    localparam int VALID_OFS = 0;
    localparam int HSYNC_OFS = 1;
    localparam int VSYNC_OFS = 2;
    localparam int CONTROL_COUNT = 3;

    typedef enum logic [1:0] {
        MODE_FILTER_OFF = 2'b00,
        MODE_FILTER_ON = 2'b01,
        MODE_LEGACY_A = 2'b10,
        MODE_LEGACY_B = 2'b11
    } link_mode_t;

    typedef enum logic [1:0] {
        PORT_STRAP = 2'b00,
        PORT_IDLE = 2'b01,
        PORT_ACTIVE = 2'b10
    } port_state_t;

endpackage

// [hdl/bit_synchroniser.sv]
// Two flip-flop synchroniser for a bus of independent level signals.
`timescale 1ns/100ps

module bit_synchroniser #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels from another domain and their synchronised copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    if (WIDTH < 1) begin : g_check
        $error("bit_synchroniser needs a width of at least one");
    end

    // The first stage is read by the second stage only.
    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// [hdl/video_port.sv]
// Parallel video port: capture, control filter, output state and straps with an APB slave.
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////////////////////////
module video_port #(
    parameter int COLOUR_W = video_port_pkg::COLOUR_WIDTH,
    parameter int FILTER_MIN = video_port_pkg::FILTER_MIN_CLOCKS
) (
    // APB register port
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [video_port_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [video_port_pkg::DATA_WIDTH-1:0] pwdata,
    output logic [video_port_pkg::DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Parallel input from the pixel source, on the pixel clock
    input wire logic pixel_clock,
    input wire logic [COLOUR_W-1:0] colour_bus_tx,
    input wire logic pixel_valid_tx,
    input wire logic horizontal_sync_tx,
    input wire logic vertical_sync_tx,
    input wire logic [2:0] reserved_inputs,
    // Display side pins
    input wire logic power_down_n,
    input wire logic link_locked,
    input wire logic [COLOUR_W-1:0] colour_bus_rx_in,
    output logic [COLOUR_W-1:0] colour_bus_rx_out,
    output logic colour_bus_rx_oe,
    output logic pixel_valid_rx,
    output logic horizontal_sync_rx,
    output logic vertical_sync_rx,
    output logic control_rx_oe,
    output logic pixel_clock_rx_enable,
    // Serial control bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    localparam int WORD_W = COLOUR_W + video_port_pkg::CONTROL_COUNT;
    localparam int VALID_BIT = COLOUR_W + video_port_pkg::VALID_OFS;
    localparam int HSYNC_BIT = COLOUR_W + video_port_pkg::HSYNC_OFS;
    localparam int VSYNC_BIT = COLOUR_W + video_port_pkg::VSYNC_OFS;
    localparam int TO_PIX_W = COLOUR_W + 6;

    if (COLOUR_W < 8 || COLOUR_W > video_port_pkg::DATA_WIDTH) begin : g_check_colour
        $error("video_port colour width must lie between 8 and the bus width");
    end
    if (FILTER_MIN < 2) begin : g_check_filter
        $error("video_port filter needs at least two clocks");
    end

    typedef struct packed {
        video_port_pkg::port_state_t state;
        logic [FILTER_MIN-1:0][WORD_W-1:0] pipe;
        logic [1:0] filt;
        logic [COLOUR_W-1:0] link_colour;
        logic link_vsync;
        logic [COLOUR_W-1:0] strap;
        logic strap_done;
        logic [COLOUR_W-1:0] colour_out;
        logic colour_oe;
        logic valid_out;
        logic hsync_out;
        logic vsync_out;
        logic control_oe;
        logic clock_out_en;
    } pix_state_t;

    typedef struct packed {
        logic edge_sel;
        logic [1:0] mode;
        logic oss;
        logic sda_pull;
        logic [video_port_pkg::DATA_WIDTH-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [COLOUR_W-1:0] strap;
        logic strap_valid;
        logic sda_out;
    } bus_state_t;

    function automatic logic addr_is(input logic [video_port_pkg::ADDR_WIDTH-1:0] a,
                                     input logic [video_port_pkg::ADDR_WIDTH-1:0] ofs);
        return a == ofs;
    endfunction

    pix_state_t x_q;
    pix_state_t x_d;
    bus_state_t b_q;
    bus_state_t b_d;
    logic [WORD_W-1:0] fall_word_q;
    logic pix_rst_n;
    logic [TO_PIX_W-1:0] to_pix_s;
    logic [7:0] to_bus_s;
    logic edge_sel_s;
    logic [1:0] mode_s;
    logic oss_s;
    logic power_s;
    logic lock_s;
    logic [COLOUR_W-1:0] strap_pins_s;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Crossings. Control bits are quasi-static, so a plain level crossing is enough for them;
    // a change of mode may give one odd pixel while both bits settle.

    bit_synchroniser #(.WIDTH(1)) u_pix_reset (
        .clk(pixel_clock),
        .rst_n(presetn),
        .async_in(1'b1),
        .sync_out(pix_rst_n)
    );

    bit_synchroniser #(.WIDTH(TO_PIX_W)) u_to_pix (
        .clk(pixel_clock),
        .rst_n(pix_rst_n),
        .async_in({b_q.edge_sel, b_q.mode, b_q.oss, power_down_n, link_locked, colour_bus_rx_in}),
        .sync_out(to_pix_s)
    );

    assign {edge_sel_s, mode_s, oss_s, power_s, lock_s, strap_pins_s} = to_pix_s;

    bit_synchroniser #(.WIDTH(8)) u_to_bus (
        .clk(pclk),
        .rst_n(presetn),
        .async_in({x_q.strap_done, reserved_inputs, sda_in, scl_in, power_down_n, link_locked}),
        .sync_out(to_bus_s)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Pixel clock domain.

    // Falling-edge capture; the rising-edge stage picks it up half a period later.
    always_ff @(negedge pixel_clock or negedge pix_rst_n) begin
        if (!pix_rst_n) begin
            fall_word_q <= '0;
        end else begin
            fall_word_q <= {vertical_sync_tx, horizontal_sync_tx, pixel_valid_tx, colour_bus_tx};
        end
    end

    always_comb begin
        logic all_same;
        logic [1:0] ctl_bit;
        logic filter_on;
        logic [COLOUR_W-1:0] idle_colour;
        logic idle_drive;
        all_same = 1'b0;
        ctl_bit = 2'b00;
        filter_on = (video_port_pkg::link_mode_t'(mode_s) == video_port_pkg::MODE_FILTER_ON);
        idle_drive = oss_s;
        idle_colour = '0;
        x_d = x_q;

        if (edge_sel_s) begin
            x_d.pipe[0] = {vertical_sync_tx, horizontal_sync_tx, pixel_valid_tx, colour_bus_tx};
        end else begin
            x_d.pipe[0] = fall_word_q;
        end
        for (int s = 1; s < FILTER_MIN; s++) begin
            x_d.pipe[s] = x_q.pipe[s-1];
        end

        // In MODE_FILTER_ON a valid or hsync level reaches the link only after FILTER_MIN equal samples, so shorter pulses vanish.
        for (int c = 0; c < 2; c++) begin
            ctl_bit[c] = x_q.pipe[FILTER_MIN-1][c == 0 ? VALID_BIT : HSYNC_BIT];
            all_same = 1'b1;
            for (int s = 0; s < FILTER_MIN; s++) begin
                if (x_q.pipe[s][c == 0 ? VALID_BIT : HSYNC_BIT] != ctl_bit[c]) begin
                    all_same = 1'b0;
                end
            end
            if (!filter_on) begin
                x_d.filt[c] = ctl_bit[c];
            end else if (all_same) begin
                x_d.filt[c] = ctl_bit[c];
            end
        end
        x_d.link_colour = x_q.pipe[FILTER_MIN-1][COLOUR_W-1:0];
        x_d.link_vsync = x_q.pipe[FILTER_MIN-1][VSYNC_BIT];

        unique case (x_q.state)
            video_port_pkg::PORT_STRAP: begin
                // Colour pins stay released so the straps can be read.
                x_d.colour_oe = 1'b0;
                x_d.colour_out = '0;
                x_d.valid_out = 1'b0;
                x_d.hsync_out = 1'b0;
                x_d.vsync_out = 1'b0;
                x_d.control_oe = idle_drive;
                x_d.clock_out_en = 1'b0;
                if (power_s) begin
                    x_d.strap = strap_pins_s;
                    x_d.strap_done = 1'b1;
                    x_d.state = video_port_pkg::PORT_IDLE;
                end
            end
            video_port_pkg::PORT_IDLE: begin
                x_d.colour_out = idle_colour;
                x_d.colour_oe = idle_drive;
                x_d.valid_out = 1'b0;
                x_d.hsync_out = 1'b0;
                x_d.vsync_out = 1'b0;
                x_d.control_oe = idle_drive;
                x_d.clock_out_en = 1'b0;
                if (power_s && lock_s) begin
                    x_d.state = video_port_pkg::PORT_ACTIVE;
                end
            end
            video_port_pkg::PORT_ACTIVE: begin
                x_d.colour_out = x_q.link_colour;
                x_d.colour_oe = 1'b1;
                x_d.valid_out = x_q.filt[0];
                x_d.hsync_out = x_q.filt[1];
                x_d.vsync_out = x_q.link_vsync;
                x_d.control_oe = 1'b1;
                x_d.clock_out_en = 1'b1;
                if (!power_s || !lock_s) begin
                    x_d.colour_out = idle_colour;
                    x_d.colour_oe = idle_drive;
                    x_d.valid_out = 1'b0;
                    x_d.hsync_out = 1'b0;
                    x_d.vsync_out = 1'b0;
                    x_d.control_oe = idle_drive;
                    x_d.clock_out_en = 1'b0;
                    x_d.state = video_port_pkg::PORT_IDLE;
                end
            end
            default: begin
                x_d.state = video_port_pkg::PORT_IDLE;
            end
        endcase
    end

    always_ff @(posedge pixel_clock or negedge pix_rst_n) begin
        if (!pix_rst_n) begin
            x_q <= '0;
        end else begin
            x_q <= x_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // APB domain. No wait state: read data and error are registered in the setup cycle.

    always_comb begin
        logic [video_port_pkg::DATA_WIDTH-1:0] rd;
        logic miss;
        rd = 32'h0000_0000;
        miss = 1'b0;
        b_d = b_q;
        b_d.sda_out = 1'b0;

        if (addr_is(paddr, video_port_pkg::CTRL_ADDR)) begin
            rd[video_port_pkg::CTRL_EDGE_BIT] = b_q.edge_sel;
            rd[video_port_pkg::CTRL_MODE_LSB +: 2] = b_q.mode;
            rd[video_port_pkg::CTRL_OSS_BIT] = b_q.oss;
            rd[video_port_pkg::CTRL_SDA_BIT] = b_q.sda_pull;
        end else if (addr_is(paddr, video_port_pkg::STATUS_ADDR)) begin
            rd[video_port_pkg::STAT_LOCK_BIT] = to_bus_s[0];
            rd[video_port_pkg::STAT_POWER_BIT] = to_bus_s[1];
            rd[video_port_pkg::STAT_SCL_BIT] = to_bus_s[2];
            rd[video_port_pkg::STAT_SDA_BIT] = to_bus_s[3];
            rd[video_port_pkg::STAT_STRAP_BIT] = b_q.strap_valid;
            rd[video_port_pkg::STAT_RESERVED_BIT] = |to_bus_s[6:4];
        end else if (addr_is(paddr, video_port_pkg::STRAP_ADDR)) begin
            rd[COLOUR_W-1:0] = b_q.strap;
        end else begin
            miss = 1'b1;
        end

        if (psel && !penable) begin
            b_d.pready = 1'b1;
            b_d.pslverr = miss;
            b_d.prdata = pwrite ? 32'h0000_0000 : rd;
        end else if (psel && penable && b_q.pready) begin
            b_d.pready = 1'b0;
            b_d.pslverr = 1'b0;
            if (pwrite && addr_is(paddr, video_port_pkg::CTRL_ADDR)) begin
                b_d.edge_sel = pwdata[video_port_pkg::CTRL_EDGE_BIT];
                b_d.mode = pwdata[video_port_pkg::CTRL_MODE_LSB +: 2];
                b_d.oss = pwdata[video_port_pkg::CTRL_OSS_BIT];
                b_d.sda_pull = pwdata[video_port_pkg::CTRL_SDA_BIT];
            end
        end else begin
            b_d.pready = 1'b0;
            b_d.pslverr = 1'b0;
        end

        // Straps are frozen once their flag is seen here, so the wide copy is safe.
        if (to_bus_s[7] && !b_q.strap_valid) begin
            b_d.strap = x_q.strap;
            b_d.strap_valid = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_q <= '{edge_sel: video_port_pkg::EDGE_RESET,
                     mode: video_port_pkg::MODE_RESET,
                     oss: video_port_pkg::OSS_RESET,
                     sda_pull: video_port_pkg::SDA_PULL_RESET,
                     default: '0};
        end else begin
            b_q <= b_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign prdata = b_q.prdata;
    assign pready = b_q.pready;
    assign pslverr = b_q.pslverr;
    assign sda_out = b_q.sda_out;
    assign sda_oe = b_q.sda_pull;
    assign colour_bus_rx_out = x_q.colour_out;
    assign colour_bus_rx_oe = x_q.colour_oe;
    assign pixel_valid_rx = x_q.valid_out;
    assign horizontal_sync_rx = x_q.hsync_out;
    assign vertical_sync_rx = x_q.vsync_out;
    assign control_rx_oe = x_q.control_oe;
    assign pixel_clock_rx_enable = x_q.clock_out_en;

endmodule

// [tb/video_port_properties.sv]
// Concurrent checks on the pins of the parallel video port.
`timescale 1ns/100ps
module video_port_properties #(
    parameter int COLOUR_W = video_port_pkg::COLOUR_WIDTH
) (
    // Register port
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [video_port_pkg::DATA_WIDTH-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Display side
    input wire logic pixel_clock,
    input wire logic power_down_n,
    input wire logic link_locked,
    input wire logic [COLOUR_W-1:0] colour_bus_rx_out,
    input wire logic colour_bus_rx_oe,
    input wire logic pixel_valid_rx,
    input wire logic horizontal_sync_rx,
    input wire logic control_rx_oe,
    input wire logic pixel_clock_rx_enable,
    input wire logic sda_out
);
////////////////////////////////////////
    chk_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready) else $error("pready missing after setup");
    chk_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready longer than one cycle");
    chk_err_empty: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready && prdata == '0) else $error("error without empty answer");
    chk_sda_open: assert property (@(posedge pclk) disable iff (!presetn)
        sda_out == 1'b0) else $error("data line driven high");
    chk_down_quiet: assert property (@(posedge pixel_clock) disable iff (!presetn)
        !power_down_n [*6] |-> colour_bus_rx_out == '0 && !pixel_valid_rx
        && !horizontal_sync_rx && !pixel_clock_rx_enable) else $error("outputs live in power-down");
    chk_unlock_out: assert property (@(posedge pixel_clock) disable iff (!presetn)
        !link_locked [*6] |-> !pixel_clock_rx_enable && !pixel_valid_rx)
        else $error("outputs live while unlocked");
    chk_active_drive: assert property (@(posedge pixel_clock) disable iff (!presetn)
        pixel_clock_rx_enable [*2] |-> colour_bus_rx_oe && control_rx_oe)
        else $error("active port not driving");
    chk_oe_pair: assert property (@(posedge pixel_clock) disable iff (!presetn)
        colour_bus_rx_oe |-> control_rx_oe) else $error("colour driven without controls");
    cover property (@(posedge pclk) pslverr);
    cover property (@(posedge pixel_clock) !power_down_n && colour_bus_rx_oe);
    cover property (@(posedge pixel_clock) $rose(pixel_clock_rx_enable));
endmodule

bind video_port video_port_properties #(.COLOUR_W(COLOUR_W)) u_video_port_properties (
    .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .pixel_clock,
    .power_down_n, .link_locked, .colour_bus_rx_out, .colour_bus_rx_oe, .pixel_valid_rx,
    .horizontal_sync_rx, .control_rx_oe, .pixel_clock_rx_enable, .sda_out
);

// [tb/pixel_source.sv]
// Behavioural pixel source feeding the parallel input of the port.
`timescale 1ns/100ps
module pixel_source (
    // Pixel clock
    input wire logic pixel_clock,
    // Parallel outputs
    output logic [23:0] colour_bus_tx,
    output logic pixel_valid_tx,
    output logic horizontal_sync_tx,
    output logic vertical_sync_tx,
    output logic [2:0] reserved_inputs
);
    assign reserved_inputs = 3'h0;
    initial begin
        colour_bus_tx = 24'h00_0000;
        pixel_valid_tx = 1'b0;
        horizontal_sync_tx = 1'b0;
        vertical_sync_tx = 1'b0;
    end
    // The long tail keeps every later pulse inside the legal transition rates.
    task automatic pulse(input int len);
        @(posedge pixel_clock);
        vertical_sync_tx <= ~vertical_sync_tx;
        pixel_valid_tx <= 1'b1;
        horizontal_sync_tx <= 1'b1;
        repeat (len) @(posedge pixel_clock);
        pixel_valid_tx <= 1'b0;
        horizontal_sync_tx <= 1'b0;
        repeat (140) @(posedge pixel_clock);
    endtask
    // Value a is only stable at the falling edge and b only at the rising edge.
    task automatic split(input logic [23:0] a, input logic [23:0] b);
        repeat (12) begin
            @(posedge pixel_clock);
            colour_bus_tx <= a;
            @(negedge pixel_clock);
            colour_bus_tx <= b;
        end
    endtask
endmodule

// [tb/video_port_tb.sv]
// Self-checking bench of the parallel video port.
`timescale 1ns/100ps
module video_port_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pixel_clock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [23:0] colour_bus_tx, colour_bus_rx_in, colour_bus_rx_out, strap_pins;
    logic pixel_valid_tx, horizontal_sync_tx, vertical_sync_tx, power_down_n, link_locked;
    logic colour_bus_rx_oe, pixel_valid_rx, horizontal_sync_rx, vertical_sync_rx;
    logic control_rx_oe, pixel_clock_rx_enable, scl_in, sda_in, sda_out, sda_oe, rd_err;
    logic [2:0] reserved_inputs;
    int error_cnt, comparisons;
    localparam logic [23:0] VAL_A = 24'h5A_3C0F;
    localparam logic [23:0] VAL_B = 24'hC3_96E1;
    video_port u_video_port (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pixel_clock, .colour_bus_tx, .pixel_valid_tx, .horizontal_sync_tx,
        .vertical_sync_tx, .reserved_inputs, .power_down_n, .link_locked, .colour_bus_rx_in,
        .colour_bus_rx_out, .colour_bus_rx_oe, .pixel_valid_rx, .horizontal_sync_rx,
        .vertical_sync_rx, .control_rx_oe, .pixel_clock_rx_enable, .scl_in, .sda_in,
        .sda_out, .sda_oe
    );
    pixel_source u_pixel_source (
        .pixel_clock, .colour_bus_tx, .pixel_valid_tx, .horizontal_sync_tx,
        .vertical_sync_tx, .reserved_inputs
    );
    // Pull-up on the data line; the strap resistors hold the colour pins when released.
    assign sda_in = sda_oe ? sda_out : 1'b1;
    assign colour_bus_rx_in = colour_bus_rx_oe ? colour_bus_rx_out : strap_pins;
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        pixel_clock = 1'b0;
        #3;
        forever #24 pixel_clock = ~pixel_clock;
    end
////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait that never sees pready.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pix(input int n);
        repeat (n) @(posedge pixel_clock);
    endtask
    task automatic test_straps();
        apb(1'b0, video_port_pkg::CTRL_ADDR, 32'h0000_0000);
        check(rd_data, 32'h0000_0001);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check(rd_err, 1'b1);
        check(rd_data, 32'h0000_0000);
        check(colour_bus_rx_oe, 1'b0);
        @(posedge pclk);
        power_down_n <= 1'b1;
        link_locked <= 1'b1;
        pix(10);
        check({pixel_clock_rx_enable, colour_bus_rx_oe}, 2'h3);
        apb(1'b0, video_port_pkg::STRAP_ADDR, 32'h0000_0000);
        check(rd_data, {8'h00, strap_pins});
        apb(1'b0, video_port_pkg::STATUS_ADDR, 32'h0000_0000);
        check(rd_data, 32'h0000_001F);
    endtask
    task automatic test_sda();
        apb(1'b1, video_port_pkg::CTRL_ADDR, 32'h0000_0011);
        // The write lands at the closing edge, so the pin is looked at one edge later.
        @(posedge pclk);
        check({sda_oe, sda_out}, 2'h2);
        apb(1'b0, video_port_pkg::STATUS_ADDR, 32'h0000_0000);
        check(rd_data[3:2], 2'h1);
    endtask
    task automatic pulse_case(input logic [1:0] mode, input int len, input logic exp);
        logic seen;
        logic vs;
        seen = 1'b0;
        apb(1'b1, video_port_pkg::CTRL_ADDR, {29'h0000_0000, mode, 1'b1});
        pix(6);
        vs = ~vertical_sync_rx;
        fork
            u_pixel_source.pulse(len);
            repeat (40) begin
                @(posedge pixel_clock);
                seen |= pixel_valid_rx & horizontal_sync_rx;
            end
        join
        check(seen, exp);
        check(vertical_sync_rx, vs);
    endtask
    task automatic test_edge(input logic rising, input logic [23:0] exp);
        apb(1'b1, video_port_pkg::CTRL_ADDR, {31'h0000_0000, rising});
        pix(6);
        u_pixel_source.split(VAL_A, VAL_B);
        check(colour_bus_rx_out, exp);
    endtask
    task automatic test_down();
        apb(1'b1, video_port_pkg::CTRL_ADDR, 32'h0000_0009);
        @(posedge pclk);
        power_down_n <= 1'b0;
        pix(8);
        check({colour_bus_rx_out, colour_bus_rx_oe, control_rx_oe}, 26'h000_0003);
        check(pixel_clock_rx_enable, 1'b0);
        apb(1'b1, video_port_pkg::CTRL_ADDR, 32'h0000_0001);
        pix(6);
        check({colour_bus_rx_oe, control_rx_oe, pixel_valid_rx}, 3'h0);
        @(posedge pclk);
        power_down_n <= 1'b1;
        link_locked <= 1'b0;
        pix(8);
        check({pixel_clock_rx_enable, colour_bus_rx_oe}, 2'h0);
        @(posedge pclk);
        link_locked <= 1'b1;
        pix(10);
        check({pixel_clock_rx_enable, colour_bus_rx_out}, {1'b1, VAL_B});
    endtask
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, power_down_n, link_locked} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        scl_in = 1'b1;
        strap_pins = 24'hA5_C396;
        pix(2);
        @(posedge pclk);
        presetn <= 1'b1;
        test_straps();
        test_sda();
        for (int m = 0; m < 4; m++)
            pulse_case(2'(m), (m == 1) ? 2 : 1, m != 1);
        pulse_case(2'h1, 3, 1'b1);
        test_edge(1'b1, VAL_B);
        test_edge(1'b0, VAL_A);
        test_down();
        results();
    end
    initial begin
        #200000;
        error_cnt++;
        results();
    end
endmodule
